// file: ioexec_map.svh
// Holds opcodes, widths and reset values for the I/O instruction executor.
// Assumes inclusion by bare name from the package and the design module.
//
// Functional notes
// - Single-bit port write copies accumulator bit 0 to bit port; carry kept.
// - Port zero write (opcode 10_0010_0000) copies accumulator to port zero.
// - Port one write copies accumulator to port one in one cycle; carry kept.
// - Two-bit port write drives accumulator bits 1 and 0 onto port bits 1, 0.
// - OR opcode ORs accumulator with memory at data pointer into accumulator.
// - RAM back-up instruction, if armed by the enabling opcode, enters power-down state, one cycle, carry kept.
// - Rotate right through carry: carry into bit 3, bit 0 becomes carry.
`ifndef IOEXEC_MAP_SVH
`define IOEXEC_MAP_SVH

`define IOEXEC_OP_W        10
`define IOEXEC_OP_BITPORT  10'h21F
`define IOEXEC_OP_PORT0    10'h220
`define IOEXEC_OP_PORT1    10'h221
`define IOEXEC_OP_PORT2    10'h222
`define IOEXEC_OP_OR       10'h019
`define IOEXEC_OP_BACKUP   10'h008
`define IOEXEC_OP_ROTR     10'h01D
`define IOEXEC_OP_PDEN_DEF 10'h002
`define IOEXEC_NIB_W       4
`define IOEXEC_NIB_RST     4'h0
`define IOEXEC_P2_RST      2'h0
`define IOEXEC_BIT_RST     1'b0

`endif

// file: ioexec_pkg.sv
// Holds the types shared by the I/O instruction executor.
// Assumes the constant header is on the include path.
`include "ioexec_map.svh"
package ioexec_pkg;
  typedef logic [`IOEXEC_OP_W-1:0] ioexec_op_t;
  typedef struct packed {
    logic [3:0] port_zero;
    logic [3:0] port_one;
    logic [1:0] two_bit;
    logic       bit_port;
  } ioexec_ports_t;
  typedef enum logic [1:0] {
    IOEXEC_PWR_RUN    = 2'b00,
    IOEXEC_PWR_ARMED  = 2'b01,
    IOEXEC_PWR_BACKUP = 2'b10
  } ioexec_pwr_t;
endpackage

// file: ioexec_core.sv
// Executes the port output, OR, RAM back-up and rotate-right instructions.
// Assumes one opcode per cycle, qualified by instr_valid, and that memory
// data at the data pointer is presented combinationally.
`timescale 1ns/1ps
`include "ioexec_map.svh"
module ioexec_core
  import ioexec_pkg::*;
#(
  parameter logic [`IOEXEC_OP_W-1:0] PDEN_OP = `IOEXEC_OP_PDEN_DEF
) (
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          rst,
  // Instruction stream.
  input  wire logic          instr_valid,
  input  wire ioexec_op_t    instr,
  // Core state in.
  input  wire logic [3:0]    acc_in,
  input  wire logic          carry_in,
  input  wire logic [3:0]    mem_data,
  // Core state updates.
  output logic               acc_we,
  output logic [3:0]         acc_out,
  output logic               carry_we,
  output logic               carry_out,
  output logic               pc_advance,
  // Port latches and power state.
  output ioexec_ports_t      ports,
  output logic               backup_mode
);
  // ==========================================================================
  // Parameter checks.
  // The enabling opcode must differ from every opcode executed here, or one
  // word would do the other operation and never arm back-up.
  if ((PDEN_OP == `IOEXEC_OP_BITPORT) ||
      (PDEN_OP == `IOEXEC_OP_PORT0) ||
      (PDEN_OP == `IOEXEC_OP_PORT1) ||
      (PDEN_OP == `IOEXEC_OP_PORT2) ||
      (PDEN_OP == `IOEXEC_OP_OR) ||
      (PDEN_OP == `IOEXEC_OP_BACKUP) ||
      (PDEN_OP == `IOEXEC_OP_ROTR)) begin : g_pden_check
    $error("Enabling opcode aliases an executed opcode.");
  end

  // ==========================================================================
  // Decode.
  logic                   is_bit;
  logic                   is_p0;
  logic                   is_p1;
  logic                   is_p2;
  logic                   is_or;
  logic                   is_bk;
  logic                   is_rr;
  logic                   is_pden;

  always_comb begin
    is_bit  = 1'b0;
    is_p0   = 1'b0;
    is_p1   = 1'b0;
    is_p2   = 1'b0;
    is_or   = 1'b0;
    is_bk   = 1'b0;
    is_rr   = 1'b0;
    is_pden = 1'b0;
    if (instr_valid) begin
      case (instr)
        `IOEXEC_OP_BITPORT: begin
          is_bit = 1'b1;
        end
        `IOEXEC_OP_PORT0: begin
          is_p0 = 1'b1;
        end
        `IOEXEC_OP_PORT1: begin
          is_p1 = 1'b1;
        end
        `IOEXEC_OP_PORT2: begin
          is_p2 = 1'b1;
        end
        `IOEXEC_OP_OR: begin
          is_or = 1'b1;
        end
        `IOEXEC_OP_BACKUP: begin
          is_bk = 1'b1;
        end
        `IOEXEC_OP_ROTR: begin
          is_rr = 1'b1;
        end
        PDEN_OP: begin
          is_pden = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Per-bit results of the two accumulator operations.
  logic [3:0]             or_res;
  logic [3:0]             rot_res;

  for (genvar b = 0; b < `IOEXEC_NIB_W; b++) begin : g_bit
    assign or_res[b] = acc_in[b] | mem_data[b];
    if (b == `IOEXEC_NIB_W - 1) begin : g_top
      assign rot_res[b] = carry_in;
    end else begin : g_low
      assign rot_res[b] = acc_in[b + 1];
    end
  end

  // ==========================================================================
  // Accumulator and carry results, handed back to the core in the same cycle.
  // Only OR and rotate ask for a write; every other opcode leaves both alone.
  always_comb begin
    acc_we    = 1'b0;
    acc_out   = acc_in;
    carry_we  = 1'b0;
    carry_out = carry_in;
    if (is_or) begin
      acc_we  = 1'b1;
      acc_out = or_res;
    end else if (is_rr) begin
      acc_we    = 1'b1;
      acc_out   = rot_res;
      carry_we  = 1'b1;
      carry_out = acc_in[0];
    end
  end

  // ==========================================================================
  // Program counter.
  // Every opcode here is one word, so each valid cycle moves the counter on,
  // including a back-up opcode that was not armed and so acts as a no-op.
  assign pc_advance = instr_valid;

  // ==========================================================================
  // Port output latches, one register per port.
  logic [3:0]             port_zero_q;
  logic [3:0]             port_one_q;
  logic [1:0]             two_bit_q;
  logic                   bit_port_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_port_q <= `IOEXEC_BIT_RST;
    end else if (is_bit) begin
      bit_port_q <= acc_in[0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_zero_q <= `IOEXEC_NIB_RST;
    end else if (is_p0) begin
      port_zero_q <= acc_in;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_one_q <= `IOEXEC_NIB_RST;
    end else if (is_p1) begin
      port_one_q <= acc_in;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      two_bit_q <= `IOEXEC_P2_RST;
    end else if (is_p2) begin
      two_bit_q <= acc_in[1:0];
    end
  end

  assign ports = {port_zero_q, port_one_q, two_bit_q, bit_port_q};

  // ==========================================================================
  // Power-down arming and RAM back-up state.
  // Arming lasts one instruction: an idle cycle or a repeated enabling opcode
  // keeps it, any other valid opcode drops it. Back-up holds until reset wakes the device.
  ioexec_pwr_t            pwr_q;
  ioexec_pwr_t            pwr_d;
  logic                   backup_q;

  always_comb begin
    pwr_d = pwr_q;
    unique case (pwr_q)
      IOEXEC_PWR_RUN: begin
        if (is_pden) begin
          pwr_d = IOEXEC_PWR_ARMED;
        end
      end
      IOEXEC_PWR_ARMED: begin
        if (is_bk) begin
          pwr_d = IOEXEC_PWR_BACKUP;
        end else if (instr_valid && !is_pden) begin
          pwr_d = IOEXEC_PWR_RUN;
        end
      end
      IOEXEC_PWR_BACKUP: begin
        pwr_d = IOEXEC_PWR_BACKUP;
      end
      default: begin
        pwr_d = IOEXEC_PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr_q <= IOEXEC_PWR_RUN;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      backup_q <= `IOEXEC_BIT_RST;
    end else begin
      backup_q <= (pwr_d == IOEXEC_PWR_BACKUP);
    end
  end

  assign backup_mode = backup_q;
endmodule

// file: ioexec_chk_sva.sv
// Assertions on the ports of the I/O instruction executor.
// Assumes it is bound to ioexec_core and sees only its ports.
`timescale 1ns/1ps
module ioexec_chk
  import ioexec_pkg::*;
#(parameter logic [9:0] PDEN_OP = 10'h002) (
  input wire logic       clk, rst, instr_valid, carry_in, acc_we,
  input wire logic       carry_we, carry_out, backup_mode, pc_advance,
  input wire ioexec_op_t instr,
  input wire logic [3:0] acc_in, mem_data, acc_out,
  input wire ioexec_ports_t ports
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic armed;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) armed <= 1'b0;
    else if (instr_valid) armed <= (instr == PDEN_OP);
  end
  AST_BIT: assert property (instr_valid && instr == 10'h21F |=>
    ports.bit_port == $past(acc_in[0])) else $error("bit port");
  AST_P0: assert property (instr_valid && instr == 10'h220 |=>
    ports.port_zero == $past(acc_in)) else $error("port zero");
  AST_P1: assert property (instr_valid && instr == 10'h221 |=>
    ports.port_one == $past(acc_in)) else $error("port one");
  AST_P2: assert property (instr_valid && instr == 10'h222 |=>
    ports.two_bit == $past(acc_in[1:0])) else $error("two-bit port");
  AST_OR: assert property (instr_valid && instr == 10'h019 |->
    acc_we && !carry_we && acc_out == (acc_in | mem_data)) else $error("or");
  AST_ROT: assert property (instr_valid && instr == 10'h01D |->
    {acc_out, carry_out} == {carry_in, acc_in} && carry_we && acc_we)
    else $error("rot");
  AST_BK: assert property (instr_valid && instr == PDEN_OP ##1
    instr_valid && instr == 10'h008 |=> backup_mode) else $error("backup");
  AST_NOBK: assert property (!backup_mode && !(instr_valid &&
    instr == 10'h008) |=> !backup_mode) else $error("spurious backup");
  AST_BKARM: assert property (armed && instr_valid &&
    instr == 10'h008 |=> backup_mode) else $error("armed backup");
  AST_BKNOP: assert property (!armed && !backup_mode && instr_valid &&
    instr == 10'h008 |=> !backup_mode) else $error("unarmed backup");
  AST_PC: assert property (pc_advance == instr_valid)
    else $error("pc advance");
endmodule
bind ioexec_core ioexec_chk #(.PDEN_OP(PDEN_OP)) i_ioexec_chk (.clk, .rst,
  .instr_valid, .carry_in, .acc_we, .carry_we, .carry_out, .backup_mode,
  .pc_advance,
  .instr, .acc_in, .mem_data, .acc_out, .ports);

// file: test_ioexec_core.sv
// Random opcode bench for the I/O instruction executor.
// Notes each expected result in a queue; a monitor compares them.
`timescale 1ns/1ps
module test_ioexec_core import ioexec_pkg::*;;
  logic          clk = 0, rst = 1, instr_valid = 0, carry_in = 0;
  logic          acc_we, carry_we, carry_out, backup_mode, aw, cw, co, arm, bk;
  logic [3:0]    acc_in = 0, mem_data = 0, acc_out, eo;
  ioexec_op_t    instr = 0;
  ioexec_ports_t ports, p;
  logic [18:0]   q[$], n;
  int            num_errors = 0, num_checks = 0;
  ioexec_op_t    ops[9] = '{10'h21F, 10'h220, 10'h221, 10'h222, 10'h019,
                            10'h008, 10'h01D, 10'h002, 10'h3FF};
  wire [18:0] got = {acc_we, acc_we ? acc_out : 4'h0, carry_we,
                     carry_we & carry_out, ports, backup_mode};
  ioexec_core i_ioexec_core (.clk, .rst, .instr_valid, .instr, .acc_in,
    .carry_in, .mem_data, .acc_we, .acc_out, .carry_we, .carry_out,
    .pc_advance(), .ports, .backup_mode);
  initial forever #10 clk = ~clk;
  task tally_and_finish;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #50us num_errors++;
    tally_and_finish;
  end
  always @(posedge clk) if (instr_valid && !rst) begin
    n = q.pop_front();
    #1 num_checks++;
    if (n !== got) begin
      num_errors++;
      $display("BAD %0t outputs differ from note", $time);
    end
  end
  initial begin
    void'($urandom(61976));
    repeat (2) begin
      {rst, instr_valid, p, bk, arm} = {1'b1, 14'h0};
      q = {};
      repeat (8) @(negedge clk);
      rst = 0;
      repeat (400) begin
        {aw, cw, eo, co} = '0;
        instr = ops[$urandom % 9];
        {acc_in, carry_in, mem_data} = 9'($urandom);
        instr_valid = $urandom % 4 != 0;
        if (instr_valid) begin
          case (instr)
            10'h21F: p.bit_port = acc_in[0];
            10'h220: p.port_zero = acc_in;
            10'h221: p.port_one = acc_in;
            10'h222: p.two_bit = acc_in[1:0];
            10'h019: {aw, eo} = {1'b1, acc_in | mem_data};
            10'h01D: {aw, cw, eo, co} = {2'b11, carry_in, acc_in};
            10'h008: bk = bk | arm;
          endcase
          arm = instr == 10'h002;
          q.push_back({aw, eo, cw, co, p, bk});
        end
        @(negedge clk);
      end
    end
    tally_and_finish;
  end
endmodule
